// ===== serial_port_pin_control.sv
/*
 * Pin control for the five pins shared with the serial unit: ownership,
 * direction and port value registers behind an AXI4-Lite slave, plus the
 * per-pin output stage. Assumes pins synchronous to aclk, a pad ring that
 * resolves pin_o/pin_oe, and a serial unit that listens to ser_enable.
 */
//
// Contract
// - Each shared pin except sck is given to serial unit or port alone.
// - A port output pin drives the level held in the port value register.
// - Writes touch output pins only; reads return the live pin levels.
// - Port value bits: miso, mosi, sck, select0, select1; upper bits reserved.
// - Ownership has miso, mosi, select0, select1 bits; none for sck.
// - A port pin follows only its direction and value bits and the open-drain bit.
// - Sck belongs to the serial unit whenever that unit is enabled.
// - Direction bit one means output, zero input, enabled or not.
// - After reset all pins are port inputs and serial unit disabled.
// - With open-drain enabled every output pin drives open-drain.
`timescale 1ns/10ps
`default_nettype none
`include "sp_pin_cfg.svh"

module serial_port_pin_control #(
	parameter int ADDR_W = 14
) (
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0]         awaddr,
	input  wire logic [2:0]                awprot,
	input  wire logic                      awvalid,
	output logic                           awready,
	// AXI4-Lite write data
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	// AXI4-Lite write response
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0]         araddr,
	input  wire logic [2:0]                arprot,
	input  wire logic                      arvalid,
	output logic                           arready,
	// AXI4-Lite read data
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	// Serial unit side
	output logic                           ser_enable,
	input  wire sp_pin_pkg::pin_vec_t      ser_out,
	output sp_pin_pkg::pin_vec_t           ser_in,
	// Pins
	input  wire sp_pin_pkg::pin_vec_t      pin_i,
	output sp_pin_pkg::pin_vec_t           pin_o,
	output sp_pin_pkg::pin_vec_t           pin_oe
);
	// Register outputs
	logic [7:0]                value_q;
	logic [7:0]                owner_q;
	logic [7:0]                dir_q;
	logic [7:0]                ctrl_q;

	// Write channel state
	sp_pin_pkg::wr_state_t     wr_state_q;
	sp_pin_pkg::wr_state_t     wr_state_d;
	logic [ADDR_W-1:0]         awaddr_q;
	logic [7:0]                wdata_q;
	logic                      wstrb0_q;
	logic [1:0]                bresp_q;
	logic [1:0]                bresp_d;

	// Read channel state
	sp_pin_pkg::rd_state_t     rd_state_q;
	sp_pin_pkg::rd_state_t     rd_state_d;
	logic [7:0]                rdata_q;
	logic [7:0]                rdata_d;
	logic [1:0]                rresp_q;
	logic [1:0]                rresp_d;

	// Handshakes
	wire                       aw_hit;
	wire                       w_hit;
	wire                       b_hit;
	wire                       ar_hit;
	wire                       r_hit;

	// Write decode
	wire [ADDR_W-1:0]          wr_addr;
	wire [7:0]                 wr_byte;
	wire                       wr_lane0;
	wire                       wr_commit;
	sp_pin_pkg::reg_sel_t      wr_sel;
	wire                       wr_value;
	wire                       wr_owner;
	wire                       wr_dir;
	wire                       wr_ctrl;

	// Read decode
	sp_pin_pkg::reg_sel_t      rd_sel;

	// Pin routing
	sp_pin_pkg::pin_vec_t      owned;
	wire                       open_drain_enable;
	sp_pin_pkg::pin_vec_t      ser_in_d;
	sp_pin_pkg::pin_vec_t      ser_in_q;

	function automatic sp_pin_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-3:0] idx;
		idx = addr[ADDR_W-1:2];
		if (idx == (ADDR_W-2)'(`IDX_PORT_PIN_VALUE))
			decode = sp_pin_pkg::SEL_VALUE;
		else if (idx == (ADDR_W-2)'(`IDX_PIN_OWNER_SELECT))
			decode = sp_pin_pkg::SEL_OWNER;
		else if (idx == (ADDR_W-2)'(`IDX_PIN_DIRECTION))
			decode = sp_pin_pkg::SEL_DIR;
		else if (idx == (ADDR_W-2)'(`IDX_PIN_CONTROL))
			decode = sp_pin_pkg::SEL_CTRL;
		else
			decode = sp_pin_pkg::SEL_NONE;
	endfunction : decode

	// Address and data are taken in either order
	assign awready = (wr_state_q == sp_pin_pkg::WR_IDLE) || (wr_state_q == sp_pin_pkg::WR_HAVE_DATA);
	assign wready  = (wr_state_q == sp_pin_pkg::WR_IDLE) || (wr_state_q == sp_pin_pkg::WR_HAVE_ADDR);
	assign bvalid  = (wr_state_q == sp_pin_pkg::WR_RESP);
	assign bresp   = bresp_q;
	assign aw_hit  = awvalid && awready;
	assign w_hit   = wvalid && wready;
	assign b_hit   = bvalid && bready;

	assign arready = (rd_state_q == sp_pin_pkg::RD_IDLE);
	assign rvalid  = (rd_state_q == sp_pin_pkg::RD_RESP);
	assign rresp   = rresp_q;
	assign rdata   = {24'h000000, rdata_q};
	assign ar_hit  = arvalid && arready;
	assign r_hit   = rvalid && rready;

	// Write path uses whichever half arrived this cycle
	assign wr_addr   = aw_hit ? awaddr : awaddr_q;
	assign wr_byte   = w_hit ? wdata[7:0] : wdata_q;
	assign wr_lane0  = w_hit ? wstrb[0] : wstrb0_q;
	assign wr_commit = (wr_state_d == sp_pin_pkg::WR_RESP) && (wr_state_q != sp_pin_pkg::WR_RESP);
	assign wr_sel    = decode(wr_addr);
	// Only the low byte lane carries register data
	assign wr_value  = wr_commit && wr_lane0 && (wr_sel == sp_pin_pkg::SEL_VALUE);
	assign wr_owner  = wr_commit && wr_lane0 && (wr_sel == sp_pin_pkg::SEL_OWNER);
	assign wr_dir    = wr_commit && wr_lane0 && (wr_sel == sp_pin_pkg::SEL_DIR);
	assign wr_ctrl   = wr_commit && wr_lane0 && (wr_sel == sp_pin_pkg::SEL_CTRL);

	always_comb begin
		wr_state_d = wr_state_q;
		case (wr_state_q)
			sp_pin_pkg::WR_IDLE: begin
				if (aw_hit && w_hit)
					wr_state_d = sp_pin_pkg::WR_RESP;
				else if (aw_hit)
					wr_state_d = sp_pin_pkg::WR_HAVE_ADDR;
				else if (w_hit)
					wr_state_d = sp_pin_pkg::WR_HAVE_DATA;
			end
			sp_pin_pkg::WR_HAVE_ADDR: begin
				if (w_hit)
					wr_state_d = sp_pin_pkg::WR_RESP;
			end
			sp_pin_pkg::WR_HAVE_DATA: begin
				if (aw_hit)
					wr_state_d = sp_pin_pkg::WR_RESP;
			end
			sp_pin_pkg::WR_RESP: begin
				if (b_hit)
					wr_state_d = sp_pin_pkg::WR_IDLE;
			end
			default: wr_state_d = sp_pin_pkg::WR_IDLE;
		endcase
	end

	assign bresp_d = wr_commit ? ((wr_sel == sp_pin_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY) : bresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= sp_pin_pkg::WR_IDLE;
			bresp_q    <= `RESP_OKAY;
		end else begin
			wr_state_q <= wr_state_d;
			bresp_q    <= bresp_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q <= '0;
			wdata_q  <= 8'h00;
			wstrb0_q <= 1'b0;
		end else begin
			if (aw_hit)
				awaddr_q <= awaddr;
			if (w_hit) begin
				wdata_q  <= wdata[7:0];
				wstrb0_q <= wstrb[0];
			end
		end
	end

	// Registers; masks zero the reserved bits
	reg_byte #(
		.MASK      (`MASK_PORT_PIN_VALUE),
		.RESET_VAL (`RST_PORT_PIN_VALUE)
	) u_value (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_value),
		.wr_data (wr_byte),
		.q       (value_q)
	);

	// Sck has no ownership bit
	reg_byte #(
		.MASK      (`MASK_PIN_OWNER_SELECT),
		.RESET_VAL (`RST_PIN_OWNER_SELECT)
	) u_owner (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_owner),
		.wr_data (wr_byte),
		.q       (owner_q)
	);

	reg_byte #(
		.MASK      (`MASK_PIN_DIRECTION),
		.RESET_VAL (`RST_PIN_DIRECTION)
	) u_dir (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_dir),
		.wr_data (wr_byte),
		.q       (dir_q)
	);

	// Serial unit starts disabled
	reg_byte #(
		.MASK      (`MASK_PIN_CONTROL),
		.RESET_VAL (`RST_PIN_CONTROL)
	) u_ctrl (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_ctrl),
		.wr_data (wr_byte),
		.q       (ctrl_q)
	);

	// Read path
	assign rd_sel = decode(araddr);

	always_comb begin
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (ar_hit) begin
			rresp_d = `RESP_OKAY;
			case (rd_sel)
				// Live pin levels, not the stored value
				sp_pin_pkg::SEL_VALUE: rdata_d = {3'b000, pin_i};
				sp_pin_pkg::SEL_OWNER: rdata_d = owner_q;
				sp_pin_pkg::SEL_DIR:   rdata_d = dir_q;
				sp_pin_pkg::SEL_CTRL:  rdata_d = ctrl_q;
				default: begin
					rdata_d = 8'h00;
					rresp_d = `RESP_SLVERR;
				end
			endcase
		end
	end

	always_comb begin
		rd_state_d = rd_state_q;
		case (rd_state_q)
			sp_pin_pkg::RD_IDLE: begin
				if (ar_hit)
					rd_state_d = sp_pin_pkg::RD_RESP;
			end
			sp_pin_pkg::RD_RESP: begin
				if (r_hit)
					rd_state_d = sp_pin_pkg::RD_IDLE;
			end
			default: rd_state_d = sp_pin_pkg::RD_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q <= sp_pin_pkg::RD_IDLE;
			rdata_q    <= 8'h00;
			rresp_q    <= `RESP_OKAY;
		end else begin
			rd_state_q <= rd_state_d;
			rdata_q    <= rdata_d;
			rresp_q    <= rresp_d;
		end
	end

	// Pin ownership
	assign ser_enable        = ctrl_q[`CTRL_SER_ENABLE];
	assign open_drain_enable = ctrl_q[`CTRL_OPEN_DRAIN];
	// Ownership only counts while the serial unit runs
	assign owned = {owner_q[`PIN_SEL1], owner_q[`PIN_SEL0], 1'b1,
	                owner_q[`PIN_MOSI], owner_q[`PIN_MISO]} & {5{ser_enable}};

	// Serial unit sees levels of its own pins only
	assign ser_in_d = pin_i & owned;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ser_in_q <= 5'h00;
		else
			ser_in_q <= ser_in_d;
	end

	assign ser_in = ser_in_q;

	// Writes reach only output pins through the direction gate
	for (genvar i = 0; i < 5; i++) begin : g_pin
		pin_cell u_cell (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.gpio_level (value_q[i]),
			.gpio_dir   (dir_q[i]),
			.owned      (owned[i]),
			.open_drain (open_drain_enable),
			.ser_level  (ser_out[i]),
			.pad_o      (pin_o[i]),
			.pad_oe     (pin_oe[i])
		);
	end
endmodule : serial_port_pin_control
`default_nettype wire

// ===== sp_pin_cfg.svh
/*
 * Offsets, field positions, write masks and reset values of the shared
 * serial pin control block. Definitions only; included by the top module and reg_byte.
 */
`ifndef SP_PIN_CFG_SVH
`define SP_PIN_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_PORT_PIN_VALUE   12'h815
`define IDX_PIN_OWNER_SELECT 12'h816
`define IDX_PIN_DIRECTION    12'h817
`define IDX_PIN_CONTROL      12'h818

// Pin positions inside every pin byte
`define PIN_MISO 0
`define PIN_MOSI 1
`define PIN_SCK  2
`define PIN_SEL0 3
`define PIN_SEL1 4

// Control register fields
`define CTRL_SER_ENABLE 0
`define CTRL_OPEN_DRAIN 1

// Implemented bits; the rest read zero and ignore writes
`define MASK_PORT_PIN_VALUE   8'h1F
`define MASK_PIN_OWNER_SELECT 8'h1B
`define MASK_PIN_DIRECTION    8'h1F
`define MASK_PIN_CONTROL      8'h03

`define RST_PORT_PIN_VALUE   8'h00
`define RST_PIN_OWNER_SELECT 8'h00
`define RST_PIN_DIRECTION    8'h00
`define RST_PIN_CONTROL      8'h00

// AXI responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== sp_pin_pkg.sv
/*
 * Types shared by the serial pin control files.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package sp_pin_pkg;
	typedef logic [4:0] pin_vec_t;
	typedef enum logic [2:0] {SEL_NONE, SEL_VALUE, SEL_OWNER, SEL_DIR, SEL_CTRL} reg_sel_t;
	typedef enum logic [1:0] {WR_IDLE, WR_HAVE_ADDR, WR_HAVE_DATA, WR_RESP} wr_state_t;
	typedef enum logic {RD_IDLE, RD_RESP} rd_state_t;
endpackage : sp_pin_pkg

`default_nettype wire

// ===== reg_byte.sv
/*
 * One byte-wide control register with a mask of implemented bits.
 * Assumes a synchronous active-low reset and a one-cycle write strobe.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sp_pin_cfg.svh"

module reg_byte #(
	parameter logic [7:0] MASK      = 8'hFF,
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Write port
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	// Stored value
	output logic      [7:0] q
);
	logic [7:0] q_d;

	// Unimplemented bits never take a one
	assign q_d = wr_en ? (wr_data & MASK) : q;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= RESET_VAL & MASK;
		else
			q <= q_d;
	end
endmodule : reg_byte
`default_nettype wire

// ===== pin_cell.sv
/*
 * Output stage of one shared pin: picks the serial unit or the port bit,
 * applies direction and open-drain mode. Assumes a pad that resolves the
 * wire from pad_o and pad_oe.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_cell (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Configuration
	input  wire logic gpio_level,
	input  wire logic gpio_dir,
	input  wire logic owned,
	input  wire logic open_drain,
	// Serial unit level
	input  wire logic ser_level,
	// Pad
	output logic      pad_o,
	output logic      pad_oe
);
	logic level;
	logic pad_o_d;
	logic pad_oe_d;

	assign level = owned ? ser_level : gpio_level;
	// Open drain only ever pulls low
	assign pad_o_d  = open_drain ? 1'b0 : level;
	assign pad_oe_d = gpio_dir & (open_drain ? ~level : 1'b1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_o  <= 1'b0;
			pad_oe <= 1'b0;
		end else begin
			pad_o  <= pad_o_d;
			pad_oe <= pad_oe_d;
		end
	end
endmodule : pin_cell
`default_nettype wire

// ===== pin_ctrl_props.sv
/*
 * Port checker for serial_port_pin_control.
 * Assumes the bind below and the top module's own port names.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_ctrl_props #(
	parameter int ADDR_W = 14
) (
	// Clock and reset
	input wire logic                 aclk,
	input wire logic                 aresetn,
	// Register bus
	input wire logic [ADDR_W-1:0]    araddr,
	input wire logic                 arvalid,
	input wire logic                 arready,
	input wire logic [31:0]          rdata,
	input wire logic [1:0]           rresp,
	input wire logic                 rvalid,
	input wire logic                 rready,
	input wire logic                 bvalid,
	// Serial unit and pins
	input wire logic                 ser_enable,
	input wire sp_pin_pkg::pin_vec_t ser_out,
	input wire sp_pin_pkg::pin_vec_t ser_in,
	input wire sp_pin_pkg::pin_vec_t pin_i,
	input wire sp_pin_pkg::pin_vec_t pin_o,
	input wire sp_pin_pkg::pin_vec_t pin_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wire logic [ADDR_W-3:0] ridx  = araddr[ADDR_W-1:2];
	wire logic              rtake = arvalid && arready;

	reset_state_a: assert property (
		$rose(aresetn) |-> pin_oe == 5'h00 && !ser_enable && !bvalid) else $error("pins not idle after reset");
	live_read_a: assert property (
		rtake && ridx == 12'h815 |=> rvalid && rdata == {27'h0, $past(pin_i)}) else $error("value read not live");
	owner_read_a: assert property (
		rtake && ridx == 12'h816 |=> rdata[31:5] == 27'h0 && !rdata[2]) else $error("owner read bad bits");
	dir_upper_a: assert property (
		rtake && ridx == 12'h817 |=> rdata[31:5] == 27'h0) else $error("direction upper bits set");
	unmapped_read_a: assert property (
		rtake && (ridx < 12'h815 || ridx > 12'h818) |=> rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read answered");
	read_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped early");
	sck_drive_a: assert property (
		$past(ser_enable && ser_out[2]) && pin_oe[2] |-> pin_o[2]) else $error("sck not from serial unit");
	ser_gate_a: assert property (
		!$past(ser_enable) |-> ser_in == 5'h00) else $error("serial input not gated");
	ser_live_a: assert property (
		(ser_in & ~$past(pin_i)) == 5'h00) else $error("serial input not from pin");
	sck_in_a: assert property (
		$past(ser_enable) |-> ser_in[2] == $past(pin_i[2])) else $error("sck input not passed");
endmodule : pin_ctrl_props

bind serial_port_pin_control pin_ctrl_props #(.ADDR_W(ADDR_W)) props_u (.aclk, .aresetn, .araddr, .arvalid,
	.arready, .rdata, .rresp, .rvalid, .rready, .bvalid, .ser_enable, .ser_out, .ser_in, .pin_i, .pin_o, .pin_oe);

`default_nettype wire

// ===== pin_load.sv
/*
 * Far side of the five pins: resolves each wire.
 * Assumes pull-ups, whose level the bench sets in far_lvl.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_load (
	// Block pads
	input wire sp_pin_pkg::pin_vec_t pin_o,
	input wire sp_pin_pkg::pin_vec_t pin_oe,
	// Released level
	input wire sp_pin_pkg::pin_vec_t far_lvl,
	// Wire
	output sp_pin_pkg::pin_vec_t     pin_i
);
	// Released pins never keep the last driven value
	assign pin_i = (pin_o & pin_oe) | (far_lvl & ~pin_oe);
endmodule : pin_load

`default_nettype wire

// ===== serial_port_pin_control_tb.sv
/*
 * Bench for serial_port_pin_control: AXI4-Lite register traffic, pin levels
 * compared with a model of the pins. Assumes pin_load on the pins.
 */
`timescale 1ns/10ps
`default_nettype none

module serial_port_pin_control_tb;
	logic                 aclk = 1'b0;
	logic                 aresetn = 1'b0;
	logic [13:0]          awaddr = 14'h0000, araddr = 14'h0000;
	logic [31:0]          wdata = 32'h0, rdata;
	logic [3:0]           wstrb = 4'h0;
	logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic                 awready, wready, bvalid, arready, rvalid, ser_enable;
	logic [1:0]           bresp, rresp;
	sp_pin_pkg::pin_vec_t ser_out = 5'h00, far_lvl = 5'h1F, ser_in, pin_i, pin_o, pin_oe;
	logic [7:0]           vv = 8'h0, ov = 8'h0, dv = 8'h0, cv = 8'h0;
	int                   miscompares = 0, checks_done = 0;

	always #12.5 aclk = ~aclk;

	serial_port_pin_control dut_u (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .ser_enable, .ser_out, .ser_in, .pin_i, .pin_o, .pin_oe);
	pin_load far_u (.pin_o, .pin_oe, .far_lvl, .pin_i);

	task automatic complete_run();
		if (miscompares == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic bound(input int n);
		if (n >= 40) begin
			check(32'h1, 32'h0);
			complete_run();
		end
	endtask : bound

	task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 40);
		bready <= 1'b0;
		bound(n);
		check({30'h0, bresp}, {30'h0, er});
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!arready && n < 40);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (!rvalid && n < 40);
		bound(n);
		// Late ready keeps the answer standing a cycle
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
		check(rdata, e);
		check({30'h0, rresp}, {30'h0, er});
		@(posedge aclk);
	endtask : rd

	task automatic wreg(input logic [11:0] i, input logic [7:0] d);
		wr({i, 2'b00}, {24'h0, d}, 4'hF, 2'h0);
		case (i)
			12'h815: vv = d & 8'h1F;
			12'h816: ov = d & 8'h1B;
			12'h817: dv = d & 8'h1F;
			default: cv = d & 8'h03;
		endcase
	endtask : wreg

	task automatic pins();
		logic [4:0] own, lvl, oe;
		// Serial input trails the pins by one stage
		repeat (2) @(posedge aclk);
		#1;
		own = cv[0] ? (ov[4:0] | 5'h04) : 5'h00;
		lvl = (own & ser_out) | (~own & vv[4:0]);
		oe = cv[1] ? (dv[4:0] & ~lvl) : dv[4:0];
		check({27'h0, pin_oe}, {27'h0, oe});
		check({27'h0, pin_o & pin_oe}, {27'h0, cv[1] ? 5'h00 : (lvl & oe)});
		check({27'h0, ser_in}, {27'h0, pin_i & own});
		check({31'h0, ser_enable}, {31'h0, cv[0]});
		@(posedge aclk);
	endtask : pins

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		pins();
		rd(14'h2054, 32'h1F, 2'h0);
		rd(14'h2058, 32'h00, 2'h0);
		rd(14'h205C, 32'h00, 2'h0);
		rd(14'h2060, 32'h00, 2'h0);
		wreg(12'h815, 8'hF5);
		wreg(12'h817, 8'hFF);
		pins();
		rd(14'h205C, 32'h1F, 2'h0);
		rd(14'h2054, 32'h15, 2'h0);
		far_lvl <= 5'h15;
		wreg(12'h817, 8'h03);
		wreg(12'h815, 8'h1E);
		pins();
		rd(14'h2054, 32'h16, 2'h0);
		wr(14'h205C, 32'h0, 4'h0, 2'h0);
		rd(14'h205C, 32'h03, 2'h0);
		wr(14'h2000, 32'hFF, 4'hF, 2'h2);
		rd(14'h2064, 32'h00, 2'h2);
		wreg(12'h816, 8'hFF);
		rd(14'h2058, 32'h1B, 2'h0);
		wreg(12'h817, 8'h1F);
		ser_out <= 5'h0A;
		pins();
		wreg(12'h818, 8'h01);
		pins();
		ser_out <= 5'h15;
		pins();
		ser_out <= 5'h0A;
		wreg(12'h816, 8'h00);
		pins();
		wreg(12'h818, 8'h03);
		pins();
		wreg(12'h817, 8'h00);
		pins();
		// Reset in mid-run must clear every register again
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		{vv, ov, dv, cv} = 32'h0;
		pins();
		rd(14'h2060, 32'h00, 2'h0);
		rd(14'h2058, 32'h00, 2'h0);
		rd(14'h2054, 32'h15, 2'h0);
		complete_run();
	end
endmodule : serial_port_pin_control_tb

`default_nettype wire
